// >>> include/power_seq_pkg.sv
// Notes on behaviour
// - Main enable high, or confirmed wake edge, turns on regulators and oscillator.
// - After settling and stable oscillator, host clock output moves to high frequency.
// - Sleep keeps MCU regulator and low-frequency clock; RF and high clock off.
// - From full power-down, a wake pin rising edge starts up like main enable.
// - Main enable must arrive within 100 us of clock switch, else power down.
// - With main enable high, control register bits choose the active mode.
// - Bit 7 set gives standby, recoverable to full operation within 100 us.
// - Bits 5 and 1 clear give mode 1, RF output off, quick recovery.
// - Bit 1 set with bit 5 clear gives mode 2: receiver on, transmitter off.
// - Bit 5 set powers whole RF section, transmitter and receiver.
// - Values 0x21/0x20 full power, 0x31/0x30 half power; bit 4 halves output.
// - Ready only after clock switch; register writes accepted only then.
// - Bit 0 selects supply: set for 5 V, clear for 3 V.
package power_seq_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  CHIP_CTRL_OFFS   = 8'h00;
   localparam logic [7:0]  SEQ_STATUS_OFFS  = 8'h04;
   localparam logic [7:0]  CHIP_CTRL_RESET  = 8'h01;

   localparam int          BIT_SUPPLY_5V    = 0;
   localparam int          BIT_RX_ONLY      = 1;
   localparam int          BIT_HALF_POWER   = 4;
   localparam int          BIT_RF_FULL      = 5;
   localparam int          BIT_STANDBY      = 7;

   // ****************************************
   // Timing
   // ****************************************
   localparam int          CLK_KHZ          = 25000;
   localparam int          EN_WINDOW_US     = 100;
   localparam int          EN_WINDOW_CYC    = (EN_WINDOW_US * CLK_KHZ) / 1000;
   localparam int          SETTLE_US        = 20;
   localparam int          SETTLE_CYC       = (SETTLE_US * CLK_KHZ + 999) / 1000;
   localparam int          TIMER_W          = 16;

   typedef enum logic [2:0] {
      ST_POWER_DOWN,
      ST_SLEEP,
      ST_STARTUP,
      ST_EN_WINDOW,
      ST_ACTIVE
   } seq_state_e;

endpackage

// >>> hdl/reader_power_mode_sequencer.sv
// Implementation choices: register access over APB and the register offsets.
module reader_power_mode_sequencer
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        main_enable_pin,
   input  wire logic        secondary_wake_pin,
   input  wire logic        osc_stable_pin,
   output logic             regulators_on,
   output logic             osc_on,
   output logic             mcu_regulator_on,
   output logic             lf_clock_on,
   output logic             hf_clock_sel,
   output logic             tx_on,
   output logic             rx_on,
   output logic             half_power,
   output logic             supply_5v_sel,
   output logic             standby_on,
   output logic             reader_ready
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] en_sync_q, wake_sync_q, osc_sync_q;
   logic       en_f_q, wake_f_q, osc_f_q, wake_prev_q;
   logic       en_f_d, wake_f_d, osc_f_d;

   // A change counts only once the second and third stages agree
   always_comb
   begin
      en_f_d   = (en_sync_q[1] == en_sync_q[2]) ? en_sync_q[2] : en_f_q;
      wake_f_d = (wake_sync_q[1] == wake_sync_q[2]) ? wake_sync_q[2] : wake_f_q;
      osc_f_d  = (osc_sync_q[1] == osc_sync_q[2]) ? osc_sync_q[2] : osc_f_q;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_sync_q   <= 3'h0;
         wake_sync_q <= 3'h0;
         osc_sync_q  <= 3'h0;
         en_f_q      <= 1'b0;
         wake_f_q    <= 1'b0;
         osc_f_q     <= 1'b0;
         wake_prev_q <= 1'b0;
      end
      else
      begin
         en_sync_q   <= {en_sync_q[1:0], main_enable_pin};
         wake_sync_q <= {wake_sync_q[1:0], secondary_wake_pin};
         osc_sync_q  <= {osc_sync_q[1:0], osc_stable_pin};
         en_f_q      <= en_f_d;
         wake_f_q    <= wake_f_d;
         osc_f_q     <= osc_f_d;
         wake_prev_q <= wake_f_q;
      end
   end

   logic wake_rise;
   assign wake_rise = wake_f_q & ~wake_prev_q;

   // ****************************************
   // Sequencer
   // ****************************************
   power_seq_pkg::seq_state_e                 state_q, state_d;
   logic [power_seq_pkg::TIMER_W-1:0]        tmr_q, tmr_d;
   logic [7:0]                               ctrl_q, ctrl_d;

   always_comb
   begin
      state_d = state_q;
      tmr_d   = tmr_q;
      case (state_q)
         power_seq_pkg::ST_POWER_DOWN:
         begin
            tmr_d = '0;
            if (en_f_q || wake_rise)
               state_d = power_seq_pkg::ST_STARTUP;
            else if (wake_f_q)
               state_d = power_seq_pkg::ST_SLEEP;
         end
         power_seq_pkg::ST_SLEEP:
         begin
            tmr_d = '0;
            if (en_f_q)
               state_d = power_seq_pkg::ST_STARTUP;
            else if (!wake_f_q)
               state_d = power_seq_pkg::ST_POWER_DOWN;
         end
         power_seq_pkg::ST_STARTUP:
         begin
            // Minimum settle time, then wait for the oscillator flag
            if (tmr_q < power_seq_pkg::TIMER_W'(power_seq_pkg::SETTLE_CYC))
               tmr_d = tmr_q + 1'b1;
            else if (osc_f_q)
            begin
               tmr_d   = '0;
               state_d = en_f_q ? power_seq_pkg::ST_ACTIVE
                                : power_seq_pkg::ST_EN_WINDOW;
            end
         end
         power_seq_pkg::ST_EN_WINDOW:
         begin
            tmr_d = tmr_q + 1'b1;
            if (en_f_q)
            begin
               tmr_d   = '0;
               state_d = power_seq_pkg::ST_ACTIVE;
            end
            else if (tmr_q >= power_seq_pkg::TIMER_W'(power_seq_pkg::EN_WINDOW_CYC - 1))
            begin
               tmr_d   = '0;
               state_d = power_seq_pkg::ST_POWER_DOWN;
            end
         end
         power_seq_pkg::ST_ACTIVE:
         begin
            tmr_d = '0;
            if (!en_f_q)
               state_d = wake_f_q ? power_seq_pkg::ST_SLEEP
                                  : power_seq_pkg::ST_POWER_DOWN;
         end
         default:
         begin
            tmr_d   = '0;
            state_d = power_seq_pkg::ST_POWER_DOWN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= power_seq_pkg::ST_POWER_DOWN;
         tmr_q   <= '0;
      end
      else
      begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   logic        ready_now;
   logic        setup_ph, access_done, ctrl_hit, stat_hit;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d;

   assign ready_now   = (state_q == power_seq_pkg::ST_EN_WINDOW) ||
                        (state_q == power_seq_pkg::ST_ACTIVE);
   assign setup_ph    = psel & ~penable;
   assign access_done = psel & penable & pready;
   assign ctrl_hit    = (paddr == power_seq_pkg::CHIP_CTRL_OFFS);
   assign stat_hit    = (paddr == power_seq_pkg::SEQ_STATUS_OFFS);

   // Answer decided in setup, one wait-free access cycle follows
   always_comb
   begin
      pready_d  = setup_ph;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (setup_ph)
      begin
         if (ctrl_hit)
         begin
            prdata_d  = {24'h00_0000, ctrl_q};
            // Refused until the switched clock shows on the output pin
            pslverr_d = pwrite & ~reader_ready;
         end
         else if (stat_hit)
         begin
            prdata_d  = {24'h00_0000, reader_ready, wake_f_q, en_f_q, 2'h0, state_q};
            pslverr_d = pwrite;
         end
         else
            pslverr_d = 1'b1;
      end
   end

   always_comb
   begin
      ctrl_d = ctrl_q;
      if (access_done && pwrite && !pslverr && ctrl_hit)
         ctrl_d = pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         ctrl_q  <= power_seq_pkg::CHIP_CTRL_RESET;
      end
      else
      begin
         prdata  <= prdata_d;
         pready  <= pready_d;
         pslverr <= pslverr_d;
         ctrl_q  <= ctrl_d;
      end
   end

   // ****************************************
   // Power domain outputs
   // ****************************************
   logic o_reg_d, o_osc_d, o_mcu_d, o_lf_d, o_hf_d, o_tx_d, o_rx_d, o_half_d;
   logic o_5v_d, o_stby_d, o_rdy_d;
   logic powered, act;

   assign powered = (state_q == power_seq_pkg::ST_STARTUP) ||
                    (state_q == power_seq_pkg::ST_EN_WINDOW) ||
                    (state_q == power_seq_pkg::ST_ACTIVE);
   assign act     = (state_q == power_seq_pkg::ST_ACTIVE);

   always_comb
   begin
      o_reg_d  = powered;
      o_osc_d  = powered;
      o_mcu_d  = powered || (state_q == power_seq_pkg::ST_SLEEP);
      o_lf_d   = (state_q == power_seq_pkg::ST_SLEEP) ||
                 (state_q == power_seq_pkg::ST_STARTUP);
      o_hf_d   = ready_now;
      o_rdy_d  = ready_now;
      o_5v_d   = ctrl_q[power_seq_pkg::BIT_SUPPLY_5V];
      // Standby overrides the RF bits
      o_stby_d = act & ctrl_q[power_seq_pkg::BIT_STANDBY];
      o_tx_d   = act & ~o_stby_d & ctrl_q[power_seq_pkg::BIT_RF_FULL];
      o_rx_d   = act & ~o_stby_d & (ctrl_q[power_seq_pkg::BIT_RF_FULL] |
                                    ctrl_q[power_seq_pkg::BIT_RX_ONLY]);
      o_half_d = o_tx_d & ctrl_q[power_seq_pkg::BIT_HALF_POWER];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         regulators_on    <= 1'b0;
         osc_on           <= 1'b0;
         mcu_regulator_on <= 1'b0;
         lf_clock_on      <= 1'b0;
         hf_clock_sel     <= 1'b0;
         tx_on            <= 1'b0;
         rx_on            <= 1'b0;
         half_power       <= 1'b0;
         supply_5v_sel    <= power_seq_pkg::CHIP_CTRL_RESET[power_seq_pkg::BIT_SUPPLY_5V];
         standby_on       <= 1'b0;
         reader_ready     <= 1'b0;
      end
      else
      begin
         regulators_on    <= o_reg_d;
         osc_on           <= o_osc_d;
         mcu_regulator_on <= o_mcu_d;
         lf_clock_on      <= o_lf_d;
         hf_clock_sel     <= o_hf_d;
         tx_on            <= o_tx_d;
         rx_on            <= o_rx_d;
         half_power       <= o_half_d;
         supply_5v_sel    <= o_5v_d;
         standby_on       <= o_stby_d;
         reader_ready     <= o_rdy_d;
      end
   end

endmodule

// >>> test/power_seq_props.sv
module power_seq_props
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pslverr,
   input wire logic       main_enable_pin,
   input wire logic       secondary_wake_pin,
   input wire logic       regulators_on,
   input wire logic       mcu_regulator_on,
   input wire logic       lf_clock_on,
   input wire logic       hf_clock_sel,
   input wire logic       tx_on,
   input wire logic       rx_on,
   input wire logic       half_power,
   input wire logic       standby_on,
   input wire logic       reader_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // Power sequencing
   // ****************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Pins pass a synchroniser, so start-up lags by a few cycles
   property p_main_start;
      $rose(main_enable_pin) && !mcu_regulator_on |-> ##[3:10] regulators_on;
   endproperty
   a_main_start: assert property (p_main_start)
      else $error("main enable did not start regulators");
   property p_wake_start;
      $rose(secondary_wake_pin) && !mcu_regulator_on |-> ##[3:10] regulators_on && lf_clock_on;
   endproperty
   a_wake_start: assert property (p_wake_start)
      else $error("wake edge did not start regulators");
   property p_sleep;
      lf_clock_on && !regulators_on |-> mcu_regulator_on && !tx_on && !rx_on && !hf_clock_sel;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep outputs wrong");
   property p_down;
      !mcu_regulator_on |-> !(regulators_on || lf_clock_on || hf_clock_sel || tx_on || rx_on);
   endproperty
   a_down: assert property (p_down)
      else $error("power-down outputs wrong");
   property p_rf_ready;
      tx_on || rx_on |-> reader_ready && hf_clock_sel;
   endproperty
   a_rf_ready: assert property (p_rf_ready)
      else $error("radio on before ready");
   property p_standby;
      standby_on |-> !tx_on && !rx_on && reader_ready;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby with radio on");
   property p_half;
      half_power |-> tx_on && rx_on;
   endproperty
   a_half: assert property (p_half)
      else $error("half power without transmitter");
   property p_refuse;
      psel && !penable && pwrite && paddr == power_seq_pkg::CHIP_CTRL_OFFS && !reader_ready
         |=> pslverr;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("early control write accepted");
endmodule

bind reader_power_mode_sequencer power_seq_props u_props
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pslverr(pslverr), .main_enable_pin(main_enable_pin),
   .secondary_wake_pin(secondary_wake_pin), .regulators_on(regulators_on),
   .mcu_regulator_on(mcu_regulator_on), .lf_clock_on(lf_clock_on),
   .hf_clock_sel(hf_clock_sel), .tx_on(tx_on), .rx_on(rx_on), .half_power(half_power),
   .standby_on(standby_on), .reader_ready(reader_ready)
);

// >>> test/host_pin_model.sv
module host_pin_model
#(
   parameter int GAP_CYC = 125000
)
(
   input  wire logic pclk,
   output logic      main_enable_pin,
   output logic      secondary_wake_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int last_q = 0;
   int now_c = 0;
   initial main_enable_pin = 1'b0;
   initial secondary_wake_pin = 1'b0;
   always @(posedge pclk) now_c <= now_c + 1;
   // Span shortened in the bench; the device does not time it
   task automatic drive(input logic is_main, input logic v);
      while (now_c - last_q < GAP_CYC) @(posedge pclk);
      if (is_main)
         main_enable_pin <= v;
      else
         secondary_wake_pin <= v;
      last_q = now_c;
   endtask
endmodule

// >>> test/test_reader_power_mode_sequencer.sv
module test_reader_power_mode_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        osc_stable_pin = 1'b0, pready, pslverr, err;
   logic [7:0]  paddr = 8'h00;
   logic [4:0]  mexp;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        main_enable_pin, secondary_wake_pin, regulators_on, osc_on, mcu_regulator_on;
   logic        lf_clock_on, hf_clock_sel, tx_on, rx_on, half_power, supply_5v_sel;
   logic        standby_on, reader_ready;
   int          n_errors = 0, cmp_count = 0, n;
   logic [7:0]  modes[$] = '{8'h21, 8'h20, 8'h31, 8'h30, 8'h03, 8'h02, 8'h01, 8'h00,
                             8'h81, 8'h80, 8'hA1};

   reader_power_mode_sequencer dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .main_enable_pin(main_enable_pin), .secondary_wake_pin(secondary_wake_pin),
      .osc_stable_pin(osc_stable_pin), .regulators_on(regulators_on), .osc_on(osc_on),
      .mcu_regulator_on(mcu_regulator_on), .lf_clock_on(lf_clock_on),
      .hf_clock_sel(hf_clock_sel), .tx_on(tx_on), .rx_on(rx_on), .half_power(half_power),
      .supply_5v_sel(supply_5v_sel), .standby_on(standby_on), .reader_ready(reader_ready)
   );
   host_pin_model #(.GAP_CYC(200)) host
   (
      .pclk(pclk), .main_enable_pin(main_enable_pin), .secondary_wake_pin(secondary_wake_pin)
   );

   always #20 pclk = ~pclk;

   // **********
   // Bench side
   // **********
   task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdata, output logic serr);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No limit of its own: pready high ends this wait, else the watchdog
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so a following call never reassigns psel in this step
      @(posedge pclk);
   endtask

   // Expected {tx, rx, half, 5v, standby} in an active state
   function automatic logic [4:0] mode_model(input logic [7:0] c);
      logic tx;
      tx = !c[7] && c[5];
      return {tx, !c[7] && (c[5] || c[1]), tx && c[4], c[0], c[7]};
   endfunction

   task automatic final_report();
      $display("mismatches %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      final_report();
   end

   initial
   begin
      void'($urandom(32'hAE4B20C8));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("reset supply", {supply_5v_sel, regulators_on}, 2'h2);
      check("reset mcu", {mcu_regulator_on, reader_ready}, 2'h0);
      apb(1'b1, 8'h00, 32'h21, rd, err);
      check("early write", err, 1'b1);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      check("ctrl kept", {err, rd}, 33'h01);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      check("unmapped", {err, rd}, {1'b1, 32'h0});
      // Wake pin raised and held, no main enable: window runs out, then sleep
      host.drive(1'b0, 1'b1);
      for (n = 0; n < 20 && regulators_on !== 1'b1; n++) @(posedge pclk);
      check("wake start", {lf_clock_on, hf_clock_sel, osc_on}, 3'b101);
      repeat (700) @(posedge pclk);
      check("osc wait", hf_clock_sel, 1'b0);
      osc_stable_pin <= 1'b1;
      for (n = 0; n < 20 && hf_clock_sel !== 1'b1; n++) @(posedge pclk);
      check("switch", {hf_clock_sel, lf_clock_on, reader_ready}, 3'b101);
      for (n = 0; n < 3000 && regulators_on !== 1'b0; n++) @(posedge pclk);
      check("window", n >= 2495 && n <= 2505, 1'b1);
      osc_stable_pin <= 1'b0;
      repeat (3) @(posedge pclk);
      check("sleep", {mcu_regulator_on, lf_clock_on}, 2'h3);
      check("sleep rf", {hf_clock_sel, tx_on, rx_on}, 3'h0);
      host.drive(1'b0, 1'b0);
      for (n = 0; n < 20 && mcu_regulator_on !== 1'b0; n++) @(posedge pclk);
      check("down", {lf_clock_on, regulators_on, hf_clock_sel}, 3'b000);
      host.drive(1'b1, 1'b1);
      for (n = 0; n < 20 && regulators_on !== 1'b1; n++) @(posedge pclk);
      osc_stable_pin <= 1'b1;
      for (n = 0; n < 700 && reader_ready !== 1'b1; n++) @(posedge pclk);
      check("main start", {regulators_on, osc_on, hf_clock_sel, lf_clock_on}, 4'hE);
      repeat (8) modes.push_back(8'($urandom_range(255)));
      foreach (modes[i])
      begin
         apb(1'b1, 8'h00, {24'h0, modes[i]}, rd, err);
         check("mode write", err, 1'b0);
         repeat (2) @(posedge pclk);
         mexp = mode_model(modes[i]);
         check("tx", tx_on, mexp[4]);
         check("rx", rx_on, mexp[3]);
         check("half", half_power, mexp[2]);
         check("supply", supply_5v_sel, mexp[1]);
         check("standby", standby_on, mexp[0]);
         apb(1'b0, 8'h00, 32'h0, rd, err);
         check("readback", {err, rd}, {1'b0, 24'h0, modes[i]});
      end
      apb(1'b0, 8'h04, 32'h0, rd, err);
      check("status", {err, rd[7], rd[2:0]}, 5'b01100);
      apb(1'b1, 8'h04, 32'hFF, rd, err);
      check("status write", err, 1'b1);
      host.drive(1'b1, 1'b0);
      for (n = 0; n < 20 && mcu_regulator_on !== 1'b0; n++) @(posedge pclk);
      check("off", {tx_on, rx_on, reader_ready, mcu_regulator_on}, 4'h0);
      // Mid-run reset must bring the control word back to its reset value
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0, rd, err);
      check("reset again", {err, rd, supply_5v_sel}, {1'b0, 32'h01, 1'b1});
      final_report();
   end
endmodule
